// *** src/scrc_pkg.sv ***
// Package of constants and types for the sleep clock and reset control block.
// Operation
// - Override value 0x1 makes deep sleep use the run divider, not divide-by-two.
// - Watchdog reset within 10 cycles of deep-sleep entry skips deep-sleep clock settings once.
// - After that one entry, later deep-sleep entries use the programmed deep-sleep settings.
// - Reset in deep sleep with main oscillator everywhere and internal off locks clocks.
// - Main-oscillator check flags only failures before start-up, never a later loss.
// - PLL on main oscillator into deep sleep on low-frequency oscillator risks wake failure.
// - Fast clock with interrupts disabled may give bad prefetch data on sleep wake.
// - The cause of the last reset is logged, and the log may be wrong.
package scrc_pkg;

    // Register byte offsets.
    localparam logic [7:0] RUN_CFG_OFS = 8'h00;
    localparam logic [7:0] DS_CFG_OFS = 8'h04;
    localparam logic [7:0] CTRL_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;
    localparam logic [7:0] INT_STATUS_OFS = 8'h10;
    localparam logic [7:0] INT_MASK_OFS = 8'h14;
    localparam logic [7:0] CAUSE_OFS = 8'h18;

    // Field positions in the configuration registers.
    localparam int SRC_LSB = 0;
    localparam int PLL_REF_INT_BIT = 2;
    localparam int PLL_OFF_BIT = 3;
    localparam int PREC_PD_BIT = 2;
    localparam int DIV_LSB = 4;

    // Control register bits, each a one-shot request.
    localparam int CTRL_SLEEP_BIT = 0;
    localparam int CTRL_DSLEEP_BIT = 1;
    localparam int CTRL_SWRST_BIT = 2;

    // Interrupt status bit positions.
    localparam int EV_WAKE = 0;
    localparam int EV_MAIN_FAIL = 1;
    localparam int EV_LOCKUP = 2;
    localparam int EV_WAKE_RISK = 3;
    localparam int EV_PREFETCH = 4;
    localparam int EV_RESET = 5;
    localparam int EV_W = 6;

    // Reset cause bits.
    localparam int CAUSE_EXT = 0;
    localparam int CAUSE_WDT = 1;
    localparam int CAUSE_SW = 2;

    // Reset values.
    localparam logic [7:0] RUN_CFG_RST = 8'h01;
    localparam logic [7:0] DS_CFG_RST = 8'h01;
    localparam logic [EV_W-1:0] INT_MASK_RST = 6'h00;

    // Clock source codes.
    localparam logic [1:0] SRC_MAIN = 2'h0;
    localparam logic [1:0] SRC_PREC = 2'h1;
    localparam logic [1:0] SRC_LOWF = 2'h2;
    localparam logic [1:0] SRC_PLL = 2'h3;
    localparam logic [3:0] DIV_OVR_QUIRK = 4'h1;

    // Source frequencies in MHz and speed thresholds.
    localparam int MAIN_MHZ = 16;
    localparam int PREC_MHZ = 16;
    localparam int PLL_MHZ = 200;
    localparam int MAX_SYS_MHZ = 80;
    localparam int PREFETCH_MHZ = 40;

    // Timing: watchdog window after entry, long reset pulse, clock rate.
    localparam int WDT_WINDOW_CYC = 10;
    localparam int CLK_MHZ = 125;
    localparam int EXT_RST_MS = 30;
    localparam int EXT_RST_CYC = EXT_RST_MS * 1000 * CLK_MHZ;
    localparam int MAIN_START_CYC = 1024;

    // Operating mode, one-hot.
    typedef enum logic [3:0] {
        SCRC_RUN = 4'h1,
        SCRC_SLEEP = 4'h2,
        SCRC_DSLEEP = 4'h4,
        SCRC_LOCKED = 4'h8
    } scrc_mode_t;

endpackage

// *** src/scrc_main_oscillator_check.sv ***
// Main oscillator start-up checker.
`timescale 1ns/100ps
module scrc_main_osc_check #(
    parameter int START_CYC = scrc_pkg::MAIN_START_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic osc_en,
    input wire logic osc_alive,
    output logic started,
    output logic fail
);
    initial begin
        if (START_CYC < 1 || START_CYC > 65535) begin
            $error("START_CYC out of range");
        end
    end

    typedef struct packed {
        logic [15:0] cnt;
        logic started;
        logic fail;
    } scrc_chk_t;

    scrc_chk_t s_r, s_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Waits for activity after enable; a loss after start-up is never seen.
    always_comb begin
        s_nxt = s_r;
        s_nxt.fail = 1'b0;
        if (!osc_en) begin
            s_nxt.cnt = 16'h0000;
        end else if (!s_r.started) begin
            if (osc_alive) begin
                s_nxt.started = 1'b1;
            end else if (s_r.cnt == 16'(START_CYC - 1)) begin
                s_nxt.fail = 1'b1;
                s_nxt.cnt = 16'h0000;
            end else begin
                s_nxt.cnt = s_r.cnt + 16'h0001;
            end
        end
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign started = s_r.started;
    assign fail = s_r.fail;
endmodule

// *** src/scrc_top.sv ***
// Sleep clock and reset control with APB register access.
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/100ps
module scrc_top #(
    parameter int EXT_RST_CYC = scrc_pkg::EXT_RST_CYC,
    parameter int MAIN_START_CYC = scrc_pkg::MAIN_START_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wake_req,
    input wire logic wdt_reset,
    input wire logic ext_reset_req,
    input wire logic main_oscillator_alive,
    input wire logic irq_enabled,
    output logic [1:0] clk_src,
    output logic [3:0] clk_div,
    output logic main_oscillator_en,
    output logic precision_internal_oscillator_en,
    output logic clocks_dead,
    output logic prefetch_invalid,
    output logic wake_at_risk,
    output logic irq
);
    initial begin
        if (EXT_RST_CYC < 1 || EXT_RST_CYC > 4194303) begin
            $error("EXT_RST_CYC out of range");
        end
    end

    typedef struct packed {
        scrc_pkg::scrc_mode_t mode;
        logic [7:0] run_clock_config;
        logic [7:0] deep_sleep_clock_config;
        logic [scrc_pkg::EV_W-1:0] ists;
        logic [scrc_pkg::EV_W-1:0] imask;
        logic [2:0] reset_cause_log;
        logic skip_ds;
        logic [3:0] entry_cnt;
        logic [21:0] ext_cnt;
        logic ext_taken;
        logic [31:0] prdata;
        logic [1:0] clk_src;
        logic [3:0] clk_div;
        logic prefetch_bad;
        logic wake_risk;
    } scrc_state_t;

    scrc_state_t s_r, s_nxt;
    logic main_started;
    logic main_fail;

    ////////////////////////////////////////////////////////////////////////////
    // System clock estimate in MHz for a source and divider.
    function automatic logic [7:0] sys_mhz(input logic [1:0] src, input logic [3:0] div);
        int f;
        f = 0;
        case (src)
            scrc_pkg::SRC_MAIN: f = scrc_pkg::MAIN_MHZ;
            scrc_pkg::SRC_PREC: f = scrc_pkg::PREC_MHZ;
            scrc_pkg::SRC_PLL: f = scrc_pkg::PLL_MHZ;
            default: f = 0;
        endcase
        return 8'(f / (int'(div) + 1));
    endfunction

    // Source field of a configuration register.
    function automatic logic [1:0] cfg_src(input logic [7:0] cfg);
        return cfg[scrc_pkg::SRC_LSB +: 2];
    endfunction

    // Divider field of a configuration register.
    function automatic logic [3:0] cfg_div(input logic [7:0] cfg);
        return cfg[scrc_pkg::DIV_LSB +: 4];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Main oscillator start-up check.
    scrc_main_osc_check #(
        .START_CYC(MAIN_START_CYC)
    ) u_chk (
        .pclk(pclk),
        .presetn(presetn),
        .osc_en(main_oscillator_en),
        .osc_alive(main_oscillator_alive),
        .started(main_started),
        .fail(main_fail)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic for bus, modes, clocks and events.
    always_comb begin
        logic setup;
        logic wr;
        logic rd;
        logic [scrc_pkg::EV_W-1:0] ev;
        logic [31:0] ctrl;
        logic ds_lf;
        logic sys_rst;
        logic [1:0] rsrc;
        logic [3:0] rdiv;
        logic [3:0] ovr;
        setup = psel && !penable;
        wr = psel && penable && pwrite;
        rd = psel && penable && !pwrite;
        ev = '0;
        ctrl = 32'h0000_0000;
        sys_rst = 1'b0;
        s_nxt = s_r;
        s_nxt.prefetch_bad = 1'b0;
        rsrc = cfg_src(s_r.run_clock_config);
        rdiv = cfg_div(s_r.run_clock_config);
        ovr = cfg_div(s_r.deep_sleep_clock_config);
        ds_lf = s_r.mode == scrc_pkg::SCRC_DSLEEP && s_r.clk_src == scrc_pkg::SRC_LOWF;

        // Register writes; control bits act as one-shot requests.
        if (wr) begin
            case (paddr)
                scrc_pkg::RUN_CFG_OFS: s_nxt.run_clock_config = pwdata[7:0];
                scrc_pkg::DS_CFG_OFS: s_nxt.deep_sleep_clock_config = pwdata[7:0];
                scrc_pkg::CTRL_OFS: ctrl = pwdata;
                scrc_pkg::INT_MASK_OFS: s_nxt.imask = pwdata[scrc_pkg::EV_W-1:0];
                default: ;
            endcase
        end

        // External reset is taken only once held long enough while in slow deep sleep.
        if (!ext_reset_req) begin
            s_nxt.ext_cnt = 22'h000000;
            s_nxt.ext_taken = 1'b0;
        end else if (!s_r.ext_taken) begin
            s_nxt.ext_cnt = s_r.ext_cnt + 22'h000001;
        end
        if (ext_reset_req && !s_r.ext_taken &&
            (!ds_lf || s_r.ext_cnt == 22'(EXT_RST_CYC - 1))) begin
            sys_rst = 1'b1;
            s_nxt.ext_taken = 1'b1;
            s_nxt.reset_cause_log = 3'h1 << scrc_pkg::CAUSE_EXT;
        end
        // A later watchdog source overwrites the log in the same cycle.
        if (wdt_reset) begin
            sys_rst = 1'b1;
            s_nxt.reset_cause_log = 3'h1 << scrc_pkg::CAUSE_WDT;
        end
        if (ctrl[scrc_pkg::CTRL_SWRST_BIT]) begin
            sys_rst = 1'b1;
            s_nxt.reset_cause_log = 3'h1 << scrc_pkg::CAUSE_SW;
        end
        ev[scrc_pkg::EV_RESET] = sys_rst;

        // Watchdog reset soon after deep-sleep entry drops the deep-sleep settings once.
        if (s_r.mode == scrc_pkg::SCRC_DSLEEP && s_r.entry_cnt != 4'hF) begin
            s_nxt.entry_cnt = s_r.entry_cnt + 4'h1;
        end
        if (wdt_reset && s_r.mode == scrc_pkg::SCRC_DSLEEP &&
            s_r.entry_cnt < 4'(scrc_pkg::WDT_WINDOW_CYC)) begin
            s_nxt.skip_ds = 1'b1;
        end

        // Mode sequencing.
        case (s_r.mode)
            scrc_pkg::SCRC_RUN: begin
                if (!sys_rst && ctrl[scrc_pkg::CTRL_DSLEEP_BIT]) begin
                    s_nxt.mode = scrc_pkg::SCRC_DSLEEP;
                    s_nxt.entry_cnt = 4'h0;
                    if (s_r.skip_ds) begin
                        s_nxt.clk_src = rsrc;
                        s_nxt.clk_div = rdiv;
                        s_nxt.skip_ds = 1'b0;
                    end else begin
                        s_nxt.clk_src = cfg_src(s_r.deep_sleep_clock_config);
                        s_nxt.clk_div = (ovr == scrc_pkg::DIV_OVR_QUIRK) ? rdiv : ovr;
                    end
                    // Hazardous combination for waking is reported.
                    s_nxt.wake_risk = rsrc == scrc_pkg::SRC_PLL &&
                        !s_r.run_clock_config[scrc_pkg::PLL_OFF_BIT] &&
                        !s_r.run_clock_config[scrc_pkg::PLL_REF_INT_BIT] &&
                        s_nxt.clk_src == scrc_pkg::SRC_LOWF;
                    ev[scrc_pkg::EV_WAKE_RISK] = s_nxt.wake_risk;
                end else if (!sys_rst && ctrl[scrc_pkg::CTRL_SLEEP_BIT]) begin
                    s_nxt.mode = scrc_pkg::SCRC_SLEEP;
                end else begin
                    s_nxt.clk_src = rsrc;
                    s_nxt.clk_div = rdiv;
                end
            end
            scrc_pkg::SCRC_SLEEP: begin
                if (wake_req || sys_rst) begin
                    s_nxt.mode = scrc_pkg::SCRC_RUN;
                    // Fast clock with interrupts off corrupts the first fetch.
                    if (wake_req && !irq_enabled &&
                        sys_mhz(rsrc, rdiv) >= 8'(scrc_pkg::PREFETCH_MHZ)) begin
                        s_nxt.prefetch_bad = 1'b1;
                        ev[scrc_pkg::EV_PREFETCH] = 1'b1;
                    end
                    ev[scrc_pkg::EV_WAKE] = wake_req;
                end
            end
            scrc_pkg::SCRC_DSLEEP: begin
                if (sys_rst && rsrc == scrc_pkg::SRC_MAIN &&
                    s_r.clk_src == scrc_pkg::SRC_MAIN &&
                    s_r.deep_sleep_clock_config[scrc_pkg::PREC_PD_BIT]) begin
                    s_nxt.mode = scrc_pkg::SCRC_LOCKED;
                    ev[scrc_pkg::EV_LOCKUP] = 1'b1;
                end else if (wake_req || sys_rst) begin
                    s_nxt.mode = scrc_pkg::SCRC_RUN;
                    s_nxt.clk_src = rsrc;
                    s_nxt.clk_div = rdiv;
                    s_nxt.wake_risk = 1'b0;
                    ev[scrc_pkg::EV_WAKE] = wake_req;
                end
            end
            scrc_pkg::SCRC_LOCKED: begin
                // Only the power-on reset leaves this state.
                s_nxt.mode = scrc_pkg::SCRC_LOCKED;
            end
            default: s_nxt.mode = scrc_pkg::SCRC_RUN;
        endcase
        ev[scrc_pkg::EV_MAIN_FAIL] = main_fail;

        // Read data is captured in the setup phase.
        if (setup) begin
            case (paddr)
                scrc_pkg::RUN_CFG_OFS: s_nxt.prdata = {24'h000000, s_r.run_clock_config};
                scrc_pkg::DS_CFG_OFS: s_nxt.prdata = {24'h000000, s_r.deep_sleep_clock_config};
                scrc_pkg::STATUS_OFS: s_nxt.prdata = {20'h00000, s_r.clk_div, s_r.clk_src,
                    s_r.skip_ds, main_started, s_r.mode};
                scrc_pkg::INT_STATUS_OFS: s_nxt.prdata = {26'h0000000, s_r.ists};
                scrc_pkg::INT_MASK_OFS: s_nxt.prdata = {26'h0000000, s_r.imask};
                scrc_pkg::CAUSE_OFS: s_nxt.prdata = {29'h00000000, s_r.reset_cause_log};
                default: s_nxt.prdata = 32'h0000_0000;
            endcase
        end

        // Sticky events; a read clears, a new event in that cycle wins.
        if (rd && paddr == scrc_pkg::INT_STATUS_OFS) begin
            s_nxt.ists = ev;
        end else begin
            s_nxt.ists = s_r.ists | ev;
        end
    end

    // State register; locked state is cleared only by presetn.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r.mode <= scrc_pkg::SCRC_RUN;
            s_r.run_clock_config <= scrc_pkg::RUN_CFG_RST;
            s_r.deep_sleep_clock_config <= scrc_pkg::DS_CFG_RST;
            s_r.ists <= '0;
            s_r.imask <= scrc_pkg::INT_MASK_RST;
            s_r.reset_cause_log <= 3'h0;
            s_r.skip_ds <= 1'b0;
            s_r.entry_cnt <= 4'hF;
            s_r.ext_cnt <= 22'h000000;
            s_r.ext_taken <= 1'b0;
            s_r.prdata <= 32'h0000_0000;
            s_r.clk_src <= scrc_pkg::SRC_PREC;
            s_r.clk_div <= 4'h0;
            s_r.prefetch_bad <= 1'b0;
            s_r.wake_risk <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign prdata = s_r.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(paddr == scrc_pkg::RUN_CFG_OFS ||
        paddr == scrc_pkg::DS_CFG_OFS || paddr == scrc_pkg::CTRL_OFS ||
        paddr == scrc_pkg::STATUS_OFS || paddr == scrc_pkg::INT_STATUS_OFS ||
        paddr == scrc_pkg::INT_MASK_OFS || paddr == scrc_pkg::CAUSE_OFS);
    assign clk_src = s_r.clk_src;
    assign clk_div = s_r.clk_div;
    assign clocks_dead = s_r.mode == scrc_pkg::SCRC_LOCKED;
    assign main_oscillator_en = !clocks_dead;
    assign precision_internal_oscillator_en = !clocks_dead &&
        !(s_r.mode == scrc_pkg::SCRC_DSLEEP &&
        s_r.deep_sleep_clock_config[scrc_pkg::PREC_PD_BIT]);
    assign prefetch_invalid = s_r.prefetch_bad;
    assign wake_at_risk = s_r.wake_risk;
    assign irq = |(s_r.ists & s_r.imask);
endmodule

// *** testbench/scrc_props.sv ***
// Concurrent checks on the ports of the sleep clock and reset control block.
`timescale 1ns/100ps
module scrc_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic wdt_reset,
    input wire logic irq_enabled,
    input wire logic [1:0] clk_src,
    input wire logic [3:0] clk_div,
    input wire logic main_oscillator_en,
    input wire logic precision_internal_oscillator_en,
    input wire logic clocks_dead,
    input wire logic prefetch_invalid,
    input wire logic wake_at_risk
);
    logic [3:0] run_div_r;
    logic [3:0] ovr_r;
    logic wdt_seen_r;

    ////////////////////////////////////////////////////////////////
    // A register write lands at an edge with the full handshake.
    wire logic wr_ok = psel && penable && pwrite && pready;

    // Shadow dividers; after a watchdog reset a skip may pend, so the divider check rests.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_div_r <= 4'h0;
            ovr_r <= 4'h0;
            wdt_seen_r <= 1'h0;
        end else begin
            if (wr_ok && paddr == scrc_pkg::RUN_CFG_OFS) begin
                run_div_r <= pwdata[7:4];
            end
            if (wr_ok && paddr == scrc_pkg::DS_CFG_OFS) begin
                ovr_r <= pwdata[7:4];
            end
            if (wdt_reset) begin
                wdt_seen_r <= 1'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // All checks run on the bus clock and rest during reset.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    slverr_map_a: assert property (psel && penable && paddr > scrc_pkg::CAUSE_OFS |-> pslverr)
        else $error("unmapped access without error response");
    slverr_phase_a: assert property (pslverr |-> psel && penable)
        else $error("error response outside access phase");
    ds_div_a: assert property (wr_ok && paddr == scrc_pkg::CTRL_OFS && pwdata[1] && !wdt_seen_r
        && !clocks_dead |=> clk_div == ((ovr_r == scrc_pkg::DIV_OVR_QUIRK) ? run_div_r : ovr_r))
        else $error("deep sleep divider wrong");
    lock_hold_a: assert property (clocks_dead |=> clocks_dead)
        else $error("locked state left without power-on reset");
    dead_osc_a: assert property (clocks_dead |-> !main_oscillator_en && !precision_internal_oscillator_en)
        else $error("oscillator running while locked");
    prefetch_pulse_a: assert property (prefetch_invalid |=> !prefetch_invalid)
        else $error("prefetch flag longer than one cycle");
    prefetch_cause_a: assert property (prefetch_invalid |-> !$past(irq_enabled))
        else $error("prefetch flag with interrupts enabled");
    risk_src_a: assert property ($rose(wake_at_risk) |-> clk_src == scrc_pkg::SRC_LOWF)
        else $error("wake risk flagged off the low-frequency source");
endmodule

bind scrc_top scrc_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .wdt_reset, .irq_enabled, .clk_src, .clk_div, .main_oscillator_en,
    .precision_internal_oscillator_en, .clocks_dead, .prefetch_invalid, .wake_at_risk);

// *** testbench/scrc_env_model.sv ***
// Model of the software levels and reset sources around the block.
`timescale 1ns/100ps
module scrc_env_model (
    input wire logic pclk,
    output logic wake_req,
    output logic wdt_reset,
    output logic ext_reset_req,
    output logic main_oscillator_alive,
    output logic irq_enabled
);
    ////////////////////////////////////////////////////////////////
    // Quiet levels from time zero; the oscillator starts dead.
    initial begin
        wake_req = 1'h0;
        wdt_reset = 1'h0;
        ext_reset_req = 1'h0;
        main_oscillator_alive = 1'h0;
        irq_enabled = 1'h1;
    end

    // A one-cycle wake request.
    task automatic wake();
        @(posedge pclk);
        wake_req <= 1'h1;
        @(posedge pclk);
        wake_req <= 1'h0;
    endtask

    // A one-cycle watchdog reset.
    task automatic wdt();
        @(posedge pclk);
        wdt_reset <= 1'h1;
        @(posedge pclk);
        wdt_reset <= 1'h0;
    endtask

    // External reset held for n cycles; the scaled long pulse honours the minimum width.
    task automatic ext_rst(input int n);
        @(posedge pclk);
        ext_reset_req <= 1'h1;
        repeat (n) @(posedge pclk);
        ext_reset_req <= 1'h0;
    endtask

    // Oscillator activity and the processor interrupt enable.
    task automatic levels(input logic alive, input logic ien);
        @(posedge pclk);
        main_oscillator_alive <= alive;
        irq_enabled <= ien;
    endtask
endmodule

// *** testbench/testbench.sv ***
// Self-checking testbench for the sleep clock and reset control block.
`timescale 1ns/100ps
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, prefetch_invalid;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic wake_req, wdt_reset, ext_reset_req, main_oscillator_alive, irq_enabled;
    logic [1:0] clk_src;
    logic [3:0] clk_div;
    logic main_oscillator_en, precision_internal_oscillator_en, clocks_dead, wake_at_risk;
    int n_fail = 0, checks_done = 0, n_pref = 0, p0;
    logic [3:0] ovs [4] = '{4'h0, 4'h1, 4'h2, 4'hF};
    logic [31:0] rcs [3] = '{32'h43, 32'h43, 32'h53};
    logic ien [3] = '{1'h0, 1'h1, 1'h0};

    ////////////////////////////////////////////////////////////////
    // Block under test with short counts, and its surroundings.
    scrc_top #(.EXT_RST_CYC(20), .MAIN_START_CYC(8)) u_scrc_top (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .wake_req, .wdt_reset,
        .ext_reset_req, .main_oscillator_alive, .irq_enabled, .clk_src, .clk_div,
        .main_oscillator_en, .precision_internal_oscillator_en, .clocks_dead, .prefetch_invalid,
        .wake_at_risk, .irq);
    scrc_env_model u_env (.pclk, .wake_req, .wdt_reset, .ext_reset_req, .main_oscillator_alive,
        .irq_enabled);

    // Clock at 125 MHz.
    initial begin
        pclk = 1'h0;
        forever #4 pclk = ~pclk;
    end

    // Count prefetch hazard pulses.
    always @(posedge pclk) begin
        if (prefetch_invalid === 1'h1) n_pref <= n_pref + 1;
    end

    ////////////////////////////////////////////////////////////////
    // Compare, count and report a mismatch.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Print the verdict and end the run.
    task automatic summarize();
        if (n_fail == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // One APB transfer: setup, then access held until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'h1 && k < 20);
        if (pready !== 1'h1) begin
            check(32'(pready), 32'h1);
            summarize();
        end
        rd = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask

    // Read and compare the masked value.
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        check(rd & m, e);
    endtask

    // Wait for a clock source, then compare source and divider.
    task automatic wait_clk(input logic [1:0] s, input logic [3:0] d);
        int k;
        k = 0;
        do begin
            @(negedge pclk);
            k++;
        end while (clk_src !== s && k < 40);
        if (clk_src !== s) begin
            check(32'(clk_src), 32'(s));
            summarize();
        end
        check(32'({clk_src, clk_div}), 32'({s, d}));
    endtask

    ////////////////////////////////////////////////////////////////
    // Main sequence of scenarios.
    initial begin
        int i, k;
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        rdchk(scrc_pkg::RUN_CFG_OFS, 32'hFFFFFFFF, 32'h1);
        rdchk(scrc_pkg::DS_CFG_OFS, 32'hFFFFFFFF, 32'h1);
        rdchk(scrc_pkg::CAUSE_OFS, 32'hFFFFFFFF, 32'h0);
        rdchk(8'h1C, 32'hFFFFFFFF, 32'h0);
        // A start-up failure interrupts only when unmasked; a later loss is never flagged.
        repeat (20) @(negedge pclk);
        check(32'(irq), 32'h0);
        wr(scrc_pkg::INT_MASK_OFS, 32'h2);
        @(negedge pclk);
        check(32'(irq), 32'h1);
        u_env.levels(1'h1, 1'h1);
        repeat (12) @(posedge pclk);
        rdchk(scrc_pkg::INT_STATUS_OFS, 32'h2, 32'h2);
        u_env.levels(1'h0, 1'h1);
        repeat (30) @(posedge pclk);
        rdchk(scrc_pkg::INT_STATUS_OFS, 32'h2, 32'h0);
        check(32'(irq), 32'h0);
        u_env.levels(1'h1, 1'h1);
        // Override values 0, 1, 2 and 15 into deep sleep and back, run divider preloaded.
        wr(scrc_pkg::RUN_CFG_OFS, 32'h51);
        for (i = 0; i < 4; i++) begin
            wr(scrc_pkg::DS_CFG_OFS, {24'h0, ovs[i], 4'h2});
            wr(scrc_pkg::CTRL_OFS, 32'h2);
            wait_clk(2'h2, (ovs[i] == 4'h1) ? 4'h5 : ovs[i]);
            u_env.wake();
            wait_clk(2'h1, 4'h5);
        end
        // Watchdog reset right after entry: one deep sleep on run settings, then normal.
        wr(scrc_pkg::DS_CFG_OFS, 32'h32);
        wr(scrc_pkg::CTRL_OFS, 32'h2);
        u_env.wdt();
        wait_clk(2'h1, 4'h5);
        rdchk(scrc_pkg::CAUSE_OFS, 32'h7, 32'h2);
        wr(scrc_pkg::CTRL_OFS, 32'h2);
        rdchk(scrc_pkg::STATUS_OFS, 32'hFCF, 32'h544);
        u_env.wake();
        wr(scrc_pkg::CTRL_OFS, 32'h2);
        wait_clk(2'h2, 4'h3);
        u_env.wake();
        wait_clk(2'h1, 4'h5);
        // PLL on the main oscillator into low-frequency deep sleep, then the internal reference.
        for (i = 0; i < 2; i++) begin
            wr(scrc_pkg::RUN_CFG_OFS, (i == 0) ? 32'h43 : 32'h47);
            wr(scrc_pkg::CTRL_OFS, 32'h2);
            wait_clk(2'h2, 4'h3);
            check(32'(wake_at_risk), 32'(i == 0));
            u_env.wake();
            wait_clk(2'h3, 4'h4);
        end
        // Sleep wake at 40 MHz with interrupts off and on, then at 33 MHz with interrupts off.
        for (i = 0; i < 3; i++) begin
            u_env.levels(1'h1, ien[i]);
            wr(scrc_pkg::RUN_CFG_OFS, rcs[i]);
            p0 = n_pref;
            wr(scrc_pkg::CTRL_OFS, 32'h1);
            u_env.wake();
            repeat (6) @(negedge pclk);
            check(32'(n_pref - p0), 32'(i == 0));
        end
        // Short and long external reset in low-frequency deep sleep.
        wr(scrc_pkg::RUN_CFG_OFS, 32'h51);
        wr(scrc_pkg::DS_CFG_OFS, 32'h02);
        wr(scrc_pkg::CTRL_OFS, 32'h2);
        wait_clk(2'h2, 4'h0);
        u_env.ext_rst(5);
        @(negedge pclk);
        check(32'(clk_src), 32'h2);
        u_env.ext_rst(25);
        wait_clk(2'h1, 4'h5);
        rdchk(scrc_pkg::CAUSE_OFS, 32'h7, 32'h1);
        wr(scrc_pkg::CTRL_OFS, 32'h4);
        rdchk(scrc_pkg::CAUSE_OFS, 32'h7, 32'h4);
        // Main oscillator everywhere with the internal one powered down, then a reset.
        wr(scrc_pkg::RUN_CFG_OFS, 32'h20);
        wr(scrc_pkg::DS_CFG_OFS, 32'h24);
        wr(scrc_pkg::CTRL_OFS, 32'h2);
        wait_clk(2'h0, 4'h2);
        repeat (12) @(posedge pclk);
        u_env.wdt();
        for (k = 0; k < 20 && clocks_dead !== 1'h1; k++) @(negedge pclk);
        check(32'({clocks_dead, main_oscillator_en, precision_internal_oscillator_en}), 32'h4);
        @(posedge pclk);
        presetn <= 1'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        wait_clk(2'h1, 4'h0);
        check(32'(clocks_dead), 32'h0);
        summarize();
    end
endmodule
